// ---- design/cmpc_defines.svh ----
// timing counts and field constants for the core memory port block
`ifndef CMPC_DEFINES_SVH
`define CMPC_DEFINES_SVH
`define CMPC_CLK_PERIOD_NS   10
`define CMPC_PULSE_NS        20
`define CMPC_PULSE_CYC       ((`CMPC_PULSE_NS + `CMPC_CLK_PERIOD_NS - 1) \
                              / `CMPC_CLK_PERIOD_NS)
`define CMPC_SETTLE_NS       20
`define CMPC_SETTLE_CYC      ((`CMPC_SETTLE_NS + `CMPC_CLK_PERIOD_NS - 1) \
                              / `CMPC_CLK_PERIOD_NS)
`define CMPC_WR_DLY_NS       20
`define CMPC_WR_DLY_CYC      ((`CMPC_WR_DLY_NS + `CMPC_CLK_PERIOD_NS - 1) \
                              / `CMPC_CLK_PERIOD_NS)
`define CMPC_DATA_W          36
`define CMPC_QADDR_W         20
`define CMPC_MODE_ONE        2'h0
`define CMPC_MODE_TWO        2'h1
`define CMPC_MODE_FOUR       2'h2
`endif

// ---- design/cmpc_pkg.sv ----
// types shared by the core memory port block
package cmpc_pkg;
  typedef enum logic [2:0] {
    CMPC_IDLE, CMPC_SETTLE, CMPC_REQ, CMPC_WAIT_RD, CMPC_WR_DLY,
    CMPC_RELEASE
  } cmpc_state_type;

  typedef struct packed {
    logic       ext_meta;
    logic       ext_sync;
    logic       ext_prev;
    logic [3:0] half_cnt;
    logic [3:0] per_cnt;
    logic [3:0] per_len;
    logic [1:0] a_width;
    logic [1:0] d_width;
    logic       phase_a;
    logic       pre_a;
    logic [5:0] dbl;
  } cmpc_clk_state_type;
endpackage

// ---- design/cmpc_clkgen.sv ----
// clock generator: phase a pulse train and six double-rate enable trains
`timescale 1ns/1ps
`default_nettype none
`include "cmpc_defines.svh"
module cmpc_clkgen
  import cmpc_pkg::*;
(
  input  wire logic       i_clk,         // 100 mhz system clock
  input  wire logic       i_rst_n,       // async reset, active low
  input  wire logic       i_ext_clk,     // external host clock pin
  output logic            o_phase_a,     // phase a pulse
  output logic            o_pre_phase_a, // interval before phase a
  output logic [5:0]      o_dbl_clk      // double-rate pulse trains
);
  cmpc_clk_state_type st_ff;
  cmpc_clk_state_type nxt_st;
  logic               fall;

  // fall detect reads only the synchronised copy, never the first stage
  assign fall = st_ff.ext_prev & ~st_ff.ext_sync;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_meta = i_ext_clk;
    nxt_st.ext_sync = st_ff.ext_meta;
    nxt_st.ext_prev = st_ff.ext_sync;
    nxt_st.per_cnt  = st_ff.per_cnt + 4'h1;
    // phase a fires on each external falling edge [RQ12]
    if (fall) begin
      nxt_st.per_len  = st_ff.per_cnt;
      nxt_st.per_cnt  = 4'h0;
      nxt_st.half_cnt = 4'h0;
      nxt_st.a_width  = 2'(`CMPC_PULSE_CYC);
      nxt_st.d_width  = 2'(`CMPC_PULSE_CYC);
    end else begin
      if (st_ff.a_width != 2'h0)
        nxt_st.a_width = st_ff.a_width - 2'h1;
      nxt_st.half_cnt = st_ff.half_cnt + 4'h1;
      // second double-rate pulse halfway through the period [RQ14]
      if (st_ff.half_cnt == {1'b0, st_ff.per_len[3:1]})
        nxt_st.d_width = 2'(`CMPC_PULSE_CYC);
      else if (st_ff.d_width != 2'h0)
        nxt_st.d_width = st_ff.d_width - 2'h1;
    end
    nxt_st.phase_a = (nxt_st.a_width != 2'h0);
    // phasing indicator: last half period before phase a [RQ13]
    nxt_st.pre_a = ~nxt_st.phase_a &
                   (st_ff.half_cnt >= {1'b0, st_ff.per_len[3:1]});
    nxt_st.dbl = {6{nxt_st.d_width != 2'h0}}; // six trains [RQ14]
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_phase_a     = st_ff.phase_a;
  assign o_pre_phase_a = st_ff.pre_a;
  assign o_dbl_clk     = st_ff.dbl;
endmodule
`default_nettype wire

// ---- design/cmpc_port.sv ----
// storage-side port of the memory bus adapter with its clock generator
// Summary of operation
// RQ1 - 36-bit pulse data, both directions
// RQ2 - odd parity; check host write parity
// RQ3 - bad read parity flags error, passes through
// RQ4 - drive quadword bits, generate word bits; code passes the host word bits through unchanged
// RQ5 - fast, slow, immediate requests together
// RQ6 - address and type settle before request
// RQ7 - read, write or both for modify
// RQ8 - module read restart marks valid data
// RQ9 - send write restart once data valid
// RQ10 - module returns address accept strobe
// RQ11 - warning strobe precedes read restart
// RQ12 - phase a pulse on external fall
// RQ13 - phasing indicator before/during phase a; code drops it during phase a
// RQ14 - six double-rate 20 ns trains
// RQ15 - host signals launched, sampled same phase
// RQ16 - accept gated by port, double-rate capture
// RQ17 - warning starts restart; later restart ignored
// RQ18 - write request waits for loaded buffer
// RQ19 - port enables follow bus mode
// RQ20 - bad address parity suppresses request
// RQ21 - drop request before changing address
`timescale 1ns/1ps
`default_nettype none
`include "cmpc_defines.svh"
module cmpc_port
  import cmpc_pkg::*;
(
  input  wire logic        i_clk,           // 100 mhz clock
  input  wire logic        i_rst_n,         // async reset, active low
  input  wire logic        i_ext_clk,       // external host clock pin
  input  wire logic        i_start,         // host cycle start, one cycle
  input  wire logic        i_rd,            // host read request
  input  wire logic        i_wr,            // host write request
  input  wire logic [21:0] i_addr,          // host address bits 14-35
  input  wire logic        i_addr_par,      // host address odd parity
  input  wire logic [1:0]  i_mode,          // bus mode one/two/four
  input  wire logic        i_buf_loaded,    // write buffer loaded
  input  wire logic [35:0] i_wr_data,       // host write data
  input  wire logic        i_wr_par,        // host write parity
  input  wire logic [35:0] i_storage_data_lines, // data pins in
  input  wire logic        i_storage_data_parity, // parity pin in
  input  wire logic [3:0]  i_address_accept_strobe, // per port
  input  wire logic [3:0]  i_data_warning_strobe,   // per port
  input  wire logic [3:0]  i_read_restart_strobe,   // per port
  output logic [35:0]      o_storage_data_lines,  // data pins out
  output logic             o_storage_data_parity, // parity pin out
  output logic             o_storage_data_oe,     // data pins driven
  output logic [21:0]      o_storage_word_address, // address pins
  output logic [3:0]       o_cycle_request_fast_line, // per port
  output logic [3:0]       o_cycle_request_slow_line, // per port
  output logic [3:0]       o_cycle_request_immediate_line, // per port
  output logic [3:0]       o_read_type_line,      // per port
  output logic [3:0]       o_write_type_line,     // per port
  output logic [3:0]       o_write_restart_strobe, // per port
  output logic             o_host_acknowledge,    // cycle accepted
  output logic             o_data_valid,          // read data valid
  output logic [35:0]      o_rd_data,             // read data to host
  output logic             o_rd_par,              // read parity to host
  output logic             o_cumulative_error_line, // data parity error
  output logic             o_addr_par_err,        // address parity error
  output logic             o_busy,                // cycle in progress
  output logic             o_phase_a,             // phase a clock
  output logic             o_pre_phase_a,         // phasing indicator
  output logic [5:0]       o_dbl_clk              // double-rate trains
);
  typedef struct packed {
    cmpc_state_type fsm;
    logic [3:0]     en;
    logic [21:0]    addr;
    logic           rd;
    logic           wr;
    logic [1:0]     cnt;
    logic [3:0]     req;
    logic [3:0]     wrs;
    logic           oe;
    logic [35:0]    dout;
    logic           pout;
    logic           acc_seen;
    logic           ack_pend;
    logic           ack;
    logic           rs_seen;
    logic           dv;
    logic [35:0]    rdata;
    logic           rpar;
    logic           err;
    logic           aerr;
    logic [3:0]     acc_m;
    logic [3:0]     acc_s;
    logic [3:0]     dw_m;
    logic [3:0]     dw_s;
    logic [3:0]     rs_m;
    logic [3:0]     rs_s;
    logic [35:0]    dat_m;
    logic [35:0]    dat_s;
    logic           par_m;
    logic           par_s;
    logic           wr_ok;
    logic           err_q;
  } cmpc_port_state_type;

  cmpc_port_state_type st_ff;
  cmpc_port_state_type nxt_st;
  logic [3:0]          sel_en;
  logic                a_par_ok;

  // odd parity check over a word plus its parity bit
  function automatic logic odd_ok(input logic [35:0] d, input logic p);
    odd_ok = ^{d, p};
  endfunction

  // port selection by bus mode and starting word [RQ19]
  function automatic logic [3:0] port_sel(input logic [1:0] m,
                                          input logic [1:0] w);
    case (m)
      `CMPC_MODE_ONE:  port_sel = 4'hF;
      `CMPC_MODE_TWO:  port_sel = w[0] ? 4'hA : 4'h5;
      `CMPC_MODE_FOUR: port_sel = 4'h1 << w;
      default:         port_sel = 4'hF;
    endcase
  endfunction

  assign sel_en   = port_sel(i_mode, i_addr[1:0]);
  assign a_par_ok = ^{i_addr, i_addr_par};

  cmpc_clkgen u_clkgen (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_ext_clk     (i_ext_clk),
    .o_phase_a     (o_phase_a),
    .o_pre_phase_a (o_pre_phase_a),
    .o_dbl_clk     (o_dbl_clk)
  );

  always_comb begin
    nxt_st = st_ff;
    // pin strobes pass two flops; only the second stage is read
    nxt_st.acc_m = i_address_accept_strobe;
    nxt_st.acc_s = st_ff.acc_m;
    nxt_st.dw_m  = i_data_warning_strobe;
    nxt_st.dw_s  = st_ff.dw_m;
    nxt_st.rs_m  = i_read_restart_strobe;
    nxt_st.rs_s  = st_ff.rs_m;
    // data pins ride the same two flops, so they stay in step with strobes
    nxt_st.dat_m = i_storage_data_lines;
    nxt_st.dat_s = st_ff.dat_m;
    nxt_st.par_m = i_storage_data_parity;
    nxt_st.par_s = st_ff.par_m;
    // error line relaunched on phase a only, held one period [RQ15]
    if (o_phase_a)
      nxt_st.err_q = st_ff.err;
    nxt_st.ack   = 1'b0;
    nxt_st.dv    = 1'b0;
    // accept gated by selected port, held for a double-rate edge [RQ16]
    if (|(st_ff.acc_s & st_ff.en) && !st_ff.acc_seen &&
        st_ff.fsm != CMPC_IDLE) begin
      nxt_st.acc_seen = 1'b1;
      nxt_st.ack_pend = 1'b1;
    end
    if (st_ff.ack_pend && o_dbl_clk[0]) begin
      nxt_st.ack_pend = 1'b0;
      nxt_st.ack      = 1'b1; // [RQ16]
    end
    case (st_ff.fsm)
      CMPC_IDLE: begin
        if (i_start) begin
          nxt_st.aerr = ~a_par_ok;
          // bad address parity: no cycle request at all [RQ20]
          if (a_par_ok) begin
            nxt_st.en   = sel_en;
            // quadword and word bits both taken from host address [RQ4]
            nxt_st.addr = i_addr;
            nxt_st.rd   = i_rd; // [RQ7]
            nxt_st.wr   = i_wr; // [RQ7]
            nxt_st.cnt  = 2'(`CMPC_SETTLE_CYC);
            nxt_st.acc_seen = 1'b0;
            nxt_st.rs_seen  = 1'b0;
            nxt_st.wr_ok    = 1'b0;
            nxt_st.fsm  = CMPC_SETTLE;
          end
        end
      end
      CMPC_SETTLE: begin
        // address and types settle before request rises [RQ6]
        if (st_ff.cnt != 2'h0) begin
          nxt_st.cnt = st_ff.cnt - 2'h1;
        end else if (st_ff.wr && !st_ff.wr_ok) begin
          // write type waits for the loaded buffer, then settles too [RQ18]
          if (i_buf_loaded) begin
            // check host write parity before forwarding [RQ2]
            nxt_st.err   = st_ff.err | ~odd_ok(i_wr_data, i_wr_par);
            nxt_st.dout  = i_wr_data;
            nxt_st.pout  = i_wr_par;
            nxt_st.wr_ok = 1'b1;
            nxt_st.cnt   = 2'(`CMPC_SETTLE_CYC);
          end
        end else begin
          nxt_st.req = st_ff.en; // all three lines together [RQ5]
          nxt_st.fsm = CMPC_REQ;
        end
      end
      CMPC_REQ: begin
        if (st_ff.acc_seen)
          nxt_st.fsm = st_ff.rd ? CMPC_WAIT_RD : CMPC_WR_DLY;
        nxt_st.cnt = 2'(`CMPC_WR_DLY_CYC);
      end
      CMPC_WAIT_RD: begin
        // warning starts restart; later read restart ignored [RQ17]
        if (!st_ff.rs_seen &&
            |((st_ff.dw_s | st_ff.rs_s) & st_ff.en)) begin // [RQ8] [RQ11]
          nxt_st.rs_seen = 1'b1;
          nxt_st.rdata   = st_ff.dat_s; // [RQ1]
          nxt_st.rpar    = st_ff.par_s;
          // bad read parity flagged, still passed on [RQ3]
          nxt_st.err = st_ff.err | ~odd_ok(st_ff.dat_s, st_ff.par_s);
          nxt_st.dv  = 1'b1;
          if (st_ff.wr) begin
            nxt_st.dout = i_wr_data;
            nxt_st.pout = i_wr_par;
            nxt_st.err  = st_ff.err | ~odd_ok(i_wr_data, i_wr_par) |
                          ~odd_ok(st_ff.dat_s, st_ff.par_s);
            nxt_st.cnt  = 2'(`CMPC_WR_DLY_CYC);
            nxt_st.fsm  = CMPC_WR_DLY;
          end else begin
            nxt_st.fsm = CMPC_RELEASE;
          end
        end
      end
      CMPC_WR_DLY: begin
        // drive data first, then restart strobe once valid [RQ9]
        nxt_st.oe = 1'b1; // [RQ1]
        if (st_ff.cnt != 2'h0) begin
          nxt_st.cnt = st_ff.cnt - 2'h1;
        end else begin
          nxt_st.wrs = st_ff.en; // [RQ9]
          nxt_st.cnt = 2'(`CMPC_PULSE_CYC);
          nxt_st.fsm = CMPC_RELEASE;
        end
      end
      CMPC_RELEASE: begin
        // drop requests before address may change [RQ21]
        nxt_st.req = 4'h0;
        if (st_ff.cnt != 2'h0) begin
          nxt_st.cnt = st_ff.cnt - 2'h1;
        end else begin
          nxt_st.wrs = 4'h0;
          nxt_st.oe  = 1'b0;
          nxt_st.wr_ok = 1'b0;
          nxt_st.fsm = CMPC_IDLE;
        end
      end
      default: nxt_st.fsm = CMPC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff     <= '0;
      st_ff.fsm <= CMPC_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // host error launched on phase a, sampled a period later [RQ15]
  assign o_cumulative_error_line = st_ff.err_q;
  assign o_addr_par_err          = st_ff.aerr;
  assign o_storage_word_address  = st_ff.addr;
  assign o_cycle_request_fast_line      = st_ff.req; // [RQ5]
  assign o_cycle_request_slow_line      = st_ff.req; // [RQ5]
  assign o_cycle_request_immediate_line = st_ff.req; // [RQ5]
  // type lines: write held off until buffer loaded [RQ18]
  assign o_read_type_line  = st_ff.rd ? st_ff.en : 4'h0;
  assign o_write_type_line = st_ff.wr_ok ? st_ff.en : 4'h0;
  assign o_write_restart_strobe = st_ff.wrs;
  assign o_storage_data_lines   = st_ff.dout;
  assign o_storage_data_parity  = st_ff.pout;
  assign o_storage_data_oe      = st_ff.oe;
  assign o_host_acknowledge     = st_ff.ack;
  assign o_data_valid           = st_ff.dv;
  assign o_rd_data              = st_ff.rdata;
  assign o_rd_par               = st_ff.rpar;
  assign o_busy                 = (st_ff.fsm != CMPC_IDLE);
endmodule
`default_nettype wire

// ---- sim/cmpc_port_properties.sv ----
// concurrent checks on the storage-side and host-side pins of the port
`timescale 1ns/1ps
`default_nettype none
module cmpc_port_properties (
  input wire logic        i_clk,                          // clock
  input wire logic        i_rst_n,                        // reset
  input wire logic        i_buf_loaded,                   // buffer ready
  input wire logic [3:0]  i_address_accept_strobe,        // accept
  input wire logic        o_data_valid,                   // read valid
  input wire logic        o_addr_par_err,                 // addr error
  input wire logic [21:0] o_storage_word_address,         // address
  input wire logic [3:0]  o_cycle_request_fast_line,      // fast
  input wire logic [3:0]  o_cycle_request_slow_line,      // slow
  input wire logic [3:0]  o_cycle_request_immediate_line, // immediate
  input wire logic [3:0]  o_read_type_line,               // read type
  input wire logic [3:0]  o_write_type_line,              // write type
  input wire logic [3:0]  o_write_restart_strobe,         // restart
  input wire logic        o_storage_data_oe,              // data driven
  input wire logic        o_host_acknowledge,             // host ack
  input wire logic        o_cumulative_error_line,        // error line
  input wire logic        o_phase_a,                      // phase a
  input wire logic        o_pre_phase_a                   // phasing
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // one request on the bus drives all three lines alike
  property p_req_same;
    o_cycle_request_fast_line == o_cycle_request_slow_line &&
    o_cycle_request_fast_line == o_cycle_request_immediate_line;
  endproperty
  a_req_same: assert property (p_req_same)
    else $error("request lines differ");
  // module latches address on request, so nothing may move under it
  property p_addr_hold;
    (|o_cycle_request_fast_line) |-> $stable(o_storage_word_address) &&
      $stable(o_read_type_line) && $stable(o_write_type_line);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address or type moved under request");
  property p_par_inhibit;
    o_addr_par_err |-> o_cycle_request_fast_line == 4'h0;
  endproperty
  a_par_inhibit: assert property (p_par_inhibit)
    else $error("request despite address parity error");
  property p_wr_restart;
    (|o_write_restart_strobe) |-> o_storage_data_oe &&
      ((o_write_restart_strobe & ~o_write_type_line) == 4'h0);
  endproperty
  a_wr_restart: assert property (p_wr_restart)
    else $error("write restart without data or write type");
  property p_wr_buf;
    (|(o_cycle_request_fast_line & o_write_type_line)) |-> i_buf_loaded;
  endproperty
  a_wr_buf: assert property (p_wr_buf)
    else $error("write request before buffer loaded");
  // two sync flops plus at most half an external period of 16 cycles
  property p_ack;
    $rose(|i_address_accept_strobe) |-> ##[1:14] o_host_acknowledge;
  endproperty
  a_ack: assert property (p_ack)
    else $error("host acknowledge late or missing");
  property p_pa_width;
    $rose(o_phase_a) |=> o_phase_a ##1 !o_phase_a;
  endproperty
  a_pa_width: assert property (p_pa_width)
    else $error("phase a width wrong");
  property p_pa_phasing;
    $rose(o_phase_a) |-> $past(o_pre_phase_a) && !o_pre_phase_a;
  endproperty
  a_pa_phasing: assert property (p_pa_phasing)
    else $error("phasing indicator wrong");
  property p_one_valid;
    o_data_valid |=> !o_data_valid [*6];
  endproperty
  a_one_valid: assert property (p_one_valid)
    else $error("second data valid in one cycle");
  // host samples the error line on phase a, so it may only move there
  property p_err_phase;
    $changed(o_cumulative_error_line) |-> $past(o_phase_a);
  endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("error line moved off phase a");
endmodule
`default_nettype wire

// ---- sim/cmpc_storage_model.sv ----
// behavioural storage module; one word deep, address ignored
`timescale 1ns/1ps
`default_nettype none
module cmpc_storage_model (
  input  wire logic        i_clk,     // bench clock
  input  wire logic        i_slow,    // answer late
  input  wire logic        i_warn,    // send warning first
  input  wire logic        i_bad_par, // return parity inverted
  input  wire logic [3:0]  i_req,     // request lines
  input  wire logic [3:0]  i_rd,      // read type lines
  input  wire logic [3:0]  i_wr_rs,   // write restart
  input  wire logic [35:0] i_data,    // bus data
  input  wire logic        i_par,     // bus parity
  output logic      [3:0]  o_acc,     // accept strobe
  output logic      [3:0]  o_warn,    // warning strobe
  output logic      [3:0]  o_rs,      // read restart
  output logic      [35:0] o_data,    // data to port
  output logic             o_par,     // parity to port
  output logic      [36:0] o_word     // stored parity and word
);
  logic [3:0] sel;
  initial begin
    o_acc = 4'h0;
    o_warn = 4'h0;
    o_rs = 4'h0;
    o_data = 36'h0;
    o_par = 1'b0;
    o_word = 37'h0;
  end
  // parity is stored as sent, never computed here
  always @(posedge i_clk)
    if (|i_wr_rs) o_word <= {i_par, i_data};
  // answer a request; warning and restart strobes held 3 cycles to pass the port's sync
  always @(posedge i_clk) begin
    if (|i_req) begin
      sel = i_req;
      repeat (i_slow ? 5 : 1) @(posedge i_clk);
      o_acc <= sel;
      if (|i_rd) begin
        repeat (3) @(posedge i_clk);
        o_data <= o_word[35:0];
        o_par <= o_word[36] ^ i_bad_par;
        if (i_warn) begin
          o_warn <= sel;
          repeat (3) @(posedge i_clk);
          o_warn <= 4'h0;
        end
        o_rs <= sel;
        repeat (3) @(posedge i_clk);
        o_rs <= 4'h0;
      end
      while (|i_req) @(posedge i_clk);
      o_acc <= 4'h0;
      // released lines show no stale word
      o_data <= ~o_data;
      o_par <= ~o_par;
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the storage port and clock generator
`timescale 1ns/1ps
`default_nettype none
`include "cmpc_defines.svh"
module tb;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_ext_clk = 1'b0;
  logic        i_start = 1'b0, i_rd = 1'b0, i_wr = 1'b0;
  logic        i_addr_par = 1'b0, i_buf_loaded = 1'b0, i_wr_par = 1'b0;
  logic        slow = 1'b0, warn = 1'b0, bad_par = 1'b0, m_par;
  logic [21:0] i_addr = 22'h0, o_storage_word_address, adr;
  logic [1:0]  i_mode = 2'h0;
  logic [35:0] i_wr_data = 36'h0, i_storage_data_lines, m_data;
  logic [35:0] o_storage_data_lines, o_rd_data;
  logic [36:0] word, rword;
  logic        i_storage_data_parity, o_storage_data_parity;
  logic        o_storage_data_oe, o_host_acknowledge, o_data_valid;
  logic        o_rd_par, o_cumulative_error_line, o_addr_par_err, o_busy;
  logic        o_phase_a, o_pre_phase_a;
  logic [5:0]  o_dbl_clk;
  logic [3:0]  i_address_accept_strobe, i_data_warning_strobe;
  logic [3:0]  i_read_restart_strobe, o_cycle_request_fast_line;
  logic [3:0]  o_cycle_request_slow_line, o_cycle_request_immediate_line;
  logic [3:0]  o_read_type_line, o_write_type_line, o_write_restart_strobe;
  logic [3:0]  mask = 4'h0, rdt, wrt;
  int          err_total = 0, comparisons = 0, cyc = 0;
  int          n_dv, n_ack, n_wrs, pa_t, pa_gap, db_t, db_gap;
  always #5 i_clk = ~i_clk;
  always #80 i_ext_clk = ~i_ext_clk;
  // shared data wire: the port wins while it drives
  assign i_storage_data_lines  = o_storage_data_oe ? o_storage_data_lines
                                                   : m_data;
  assign i_storage_data_parity = o_storage_data_oe ? o_storage_data_parity
                                                   : m_par;
  cmpc_port DUT (.*);
  cmpc_storage_model u_mem (
    .i_clk(i_clk), .i_slow(slow), .i_warn(warn), .i_bad_par(bad_par),
    .i_req(o_cycle_request_fast_line), .i_rd(o_read_type_line),
    .i_wr_rs(o_write_restart_strobe), .i_data(i_storage_data_lines),
    .i_par(i_storage_data_parity), .o_acc(i_address_accept_strobe),
    .o_warn(i_data_warning_strobe), .o_rs(i_read_restart_strobe),
    .o_data(m_data), .o_par(m_par), .o_word(word));
  // pin monitor; cleared by the start pulse so it is the sole driver
  always @(posedge i_clk) begin
    if (i_start) begin
      mask <= 4'h0;
      n_dv <= 0;
      n_ack <= 0;
      n_wrs <= 0;
    end else begin
      if (|o_cycle_request_fast_line && mask === 4'h0) begin
        mask <= o_cycle_request_fast_line;
        rdt <= o_read_type_line;
        wrt <= o_write_type_line;
        adr <= o_storage_word_address;
      end
      if (o_data_valid === 1'b1) rword <= {o_rd_par, o_rd_data};
      n_dv <= n_dv + (o_data_valid === 1'b1);
      n_ack <= n_ack + (o_host_acknowledge === 1'b1);
      n_wrs <= n_wrs + (|o_write_restart_strobe === 1'b1);
    end
    if ($rose(o_phase_a)) begin
      pa_t <= cyc;
      pa_gap <= cyc - pa_t;
    end
    if ($rose(o_dbl_clk[0])) begin
      db_t <= cyc;
      db_gap <= cyc - db_t;
    end
  end
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic check(input string what, input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one host cycle; buffer stays empty 6 cycles to catch early writes
  task automatic run(input logic r, w, input logic [1:0] m, lo,
                     input logic [35:0] d, input logic bad_ap);
    @(posedge i_clk);
    i_rd <= r;
    i_wr <= w;
    i_mode <= m;
    i_addr <= {20'h24C6E, lo};
    i_addr_par <= ~^{20'h24C6E, lo} ^ bad_ap;
    i_wr_data <= d;
    i_wr_par <= ~^d;
    i_buf_loaded <= 1'b0;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    repeat (6) @(posedge i_clk);
    if (w) check("early request", mask, 4'h0);
    i_buf_loaded <= 1'b1;
    for (int k = 0; k < 300 && o_busy === 1'b1; k++) @(posedge i_clk);
    repeat (30) @(posedge i_clk);
  endtask
  task automatic t_write();
    run(1'b0, 1'b1, `CMPC_MODE_FOUR, 2'h2, 36'h9A5C30F1E, 1'b0);
    check("write port", mask, 4'h4);
    check("write type", {rdt, wrt}, 8'h04);
    check("address", adr, {20'h24C6E, 2'h2});
    check("stored word", word, {~^36'h9A5C30F1E, 36'h9A5C30F1E});
    // strobe stands over the release count, both end points included
    check("write restart cycles", n_wrs, `CMPC_PULSE_CYC + 1);
    check("host ack", n_ack, 1);
    $display("write test done");
  endtask
  task automatic t_read(input logic sl, wn);
    slow <= sl;
    warn <= wn;
    run(1'b1, 1'b0, `CMPC_MODE_FOUR, 2'h2, 36'h0, 1'b0);
    check("read type", {rdt, wrt}, 8'h40);
    check("read word", rword, {~^36'h9A5C30F1E, 36'h9A5C30F1E});
    check("data valid count", n_dv, 1);
    check("error line", o_cumulative_error_line, 1'b0);
    $display("read test done");
  endtask
  task automatic t_modes();
    logic [1:0] md [4] = '{`CMPC_MODE_ONE, `CMPC_MODE_TWO, `CMPC_MODE_TWO,
                           `CMPC_MODE_FOUR};
    logic [1:0] lo [4] = '{2'h0, 2'h0, 2'h1, 2'h3};
    logic [3:0] ex [4] = '{4'hF, 4'h5, 4'hA, 4'h8};
    for (int i = 0; i < 4; i++) begin
      run(1'b1, 1'b0, md[i], lo[i], 36'h0, 1'b0);
      check("port mask", mask, ex[i]);
    end
    $display("bus mode test done");
  endtask
  task automatic t_rmw();
    run(1'b1, 1'b1, `CMPC_MODE_FOUR, 2'h1, 36'h63B1DE482, 1'b0);
    check("modify types", {mask, rdt, wrt}, 12'h222);
    check("old word", rword, {~^36'h9A5C30F1E, 36'h9A5C30F1E});
    check("new word", word, {~^36'h63B1DE482, 36'h63B1DE482});
    $display("read modify write test done");
  endtask
  task automatic t_apar();
    run(1'b1, 1'b0, `CMPC_MODE_ONE, 2'h0, 36'h0, 1'b1);
    check("address error", o_addr_par_err, 1'b1);
    check("suppressed request", mask, 4'h0);
    $display("address parity test done");
  endtask
  task automatic t_clk();
    repeat (40) begin
      @(posedge i_clk);
      check("six trains", o_dbl_clk, {6{o_dbl_clk[0]}});
    end
    check("phase a period", pa_gap, 16);
    check("double rate period", db_gap, 8);
    $display("clock test done");
  endtask
  // last, because the error line stays set until reset
  task automatic t_badpar();
    bad_par <= 1'b1;
    run(1'b1, 1'b0, `CMPC_MODE_FOUR, 2'h3, 36'h0, 1'b0);
    check("bad parity word", rword, {^36'h63B1DE482, 36'h63B1DE482});
    check("error line", o_cumulative_error_line, 1'b1);
    $display("read parity error test done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (40) @(posedge i_clk);
    t_write();
    t_read(1'b0, 1'b0);
    t_read(1'b1, 1'b1);
    t_modes();
    t_rmw();
    t_apar();
    t_clk();
    t_badpar();
    end_of_test();
  end
endmodule
bind cmpc_port cmpc_port_properties u_props (.*);
`default_nettype wire
